// ==== design/fault_irq_pkg.sv ====
// Purpose: Shared constants for the fault interrupt enable registers.
// Assumes: A 16-bit register word behind the device register port.
// Notes:   Two-bit enable fields use separate read and write codes.
package fault_irq_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;
    localparam int          NUM_BOOST       = 7;
    localparam int          NUM_LED         = 4;
    localparam int          NUM_SRC         = NUM_BOOST + NUM_LED;
    localparam logic [7:0]  BOOST_EN_OFFSET = 8'h0a;
    localparam logic [7:0]  LED_EN_OFFSET   = 8'h0c;
    localparam logic [15:0] BOOST_EN_RESET  = 16'ha028;
    localparam logic [15:0] LED_EN_RESET    = 16'h00aa;
    localparam logic [1:0]  WR_ENABLE       = 2'h3;
    localparam logic [1:0]  WR_DISABLE      = 2'h1;
    localparam logic [1:0]  RD_ENABLED      = 2'h2;
    localparam logic [1:0]  RD_DISABLED     = 2'h0;
    // Low bit of each field: boost fields at 14..2, LED fields at 6..0.
    localparam int          BOOST_LSB0      = 2;
    localparam int          LED_LSB0        = 0;
    // Bit order of the enable vector: LED fields low, boost fields high.
    localparam int          LED_STRING_IDX  = 0;
    localparam int          BAD_STRING_IDX  = 1;
    localparam int          BUS_TIMEOUT_IDX = 2;
    localparam int          GLOBAL_IDX      = 3;
endpackage

// ==== design/enable_field.sv ====
`timescale 1ns/100ps
// Purpose: One two-bit interrupt enable field with command write codes.
// Assumes: Write strobe and data are synchronous to clk.
// Notes:   Only the enable and disable codes change the stored state.
module enable_field #(
    parameter bit RESET_ON = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wrStrobe,
    input  wire logic [1:0] wrCode,
    output logic            enabled
);
    import fault_irq_pkg::*;

    logic next_enabled;

    always_comb begin
        next_enabled = enabled;
        if (wrStrobe && wrCode == WR_ENABLE) begin
            next_enabled = 1'b1; // R1
        end else if (wrStrobe && wrCode == WR_DISABLE) begin
            next_enabled = 1'b0; // R2
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enabled <= RESET_ON;
        end else begin
            enabled <= next_enabled; // R18
        end
    end
endmodule // enable_field

// ==== design/fault_interrupt_enables.sv ====
`timescale 1ns/100ps
// Purpose: Two fault interrupt enable registers gating the interrupt pin.
// Assumes: Register port access is single-cycle and synchronous to clk.
// Notes:   Read data and the interrupt output are registered.

// Behaviour
// R1: Write code 3h enables the source.
// R2: Write code 1h disables the source.
// R3: Enabled field reads back as 2h.
// R4: Disabled field reads back as 0h.
// R5: Boost register at 0Ah, resets to A028h.
// R6: Bits 15-14: over-temperature, reset enabled.
// R7: Bits 13-12: current resistor short, reset enabled.
// R8: Bits 11-10: string resistor missing, reset disabled.
// R9: Bits 9-8: mode resistor missing, reset disabled.
// R10: Bits 7-6: frequency resistor missing, reset disabled.
// R11: Bits 5-4: boost over-current, reset enabled.
// R12: Bits 3-2: boost over-voltage high, reset enabled.
// R13: Reserved bits reset zero, no function.
// R14: LED register at 0Ch, resets to AAh.
// R15: Bits 5-4: serial bus timeout.
// R16: Bits 3-2: invalid string configuration.
// R17: Bits 1-0: shared LED string faults.
// R18: Only enabled faults drive interrupt; others hold.
// R19: Software clears latched faults elsewhere.
module fault_interrupt_enables #(
    parameter int NUM_SOURCES = fault_irq_pkg::NUM_SRC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    input  wire logic [fault_irq_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [fault_irq_pkg::DATA_W-1:0]  regWdata,
    input  wire logic [NUM_SOURCES-1:0]            faultLatched,
    output logic      [fault_irq_pkg::DATA_W-1:0]  regRdata,
    output logic                                   regHit,
    output logic      [NUM_SOURCES-1:0]            enableState,
    output logic                                   irqOut
);
    import fault_irq_pkg::*;

    // -----------------------------------------------------------------
    // Elaboration check
    // -----------------------------------------------------------------
    if (NUM_SOURCES != NUM_SRC) begin : g_bad_sources
        $error("NUM_SOURCES must match the number of enable fields.");
    end

    // Returns the read code for a stored enable state.
    function automatic logic [1:0] read_code(input logic on);
        return on ? RD_ENABLED : RD_DISABLED; // R3 R4
    endfunction

    logic                  boostSel;
    logic                  ledSel;
    logic [NUM_SRC-1:0]    fieldOn;
    logic [DATA_W-1:0]     next_regRdata;
    logic                  next_regHit;
    logic [NUM_SRC-1:0]    next_enableState;
    logic                  next_irqOut;

    assign boostSel = regAddr == BOOST_EN_OFFSET; // R5
    assign ledSel   = regAddr == LED_EN_OFFSET;   // R14

    // -----------------------------------------------------------------
    // Enable fields
    // -----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_LED; i++) begin : g_led
            localparam int LSB = LED_LSB0 + 2 * i;
            enable_field #(
                .RESET_ON (LED_EN_RESET[LSB+1])
            ) u_field (
                .clk      (clk),
                .rst_n    (rst_n),
                .wrStrobe (regWrite && ledSel),
                .wrCode   (regWdata[LSB+1:LSB]),
                .enabled  (fieldOn[i])
            ); // R14 R15 R16 R17
        end
        for (i = 0; i < NUM_BOOST; i++) begin : g_boost
            localparam int LSB = BOOST_LSB0 + 2 * i;
            enable_field #(
                .RESET_ON (BOOST_EN_RESET[LSB+1])
            ) u_field (
                .clk      (clk),
                .rst_n    (rst_n),
                .wrStrobe (regWrite && boostSel),
                .wrCode   (regWdata[LSB+1:LSB]),
                .enabled  (fieldOn[NUM_LED+i])
            ); // R6 R7 R8 R9 R10 R11 R12
        end
    endgenerate

    // -----------------------------------------------------------------
    // Read path and interrupt gating
    // -----------------------------------------------------------------
    always_comb begin
        next_regRdata = regRdata;
        next_regHit   = 1'b0;
        if (regRead) begin
            next_regRdata = '0; // R13
            if (boostSel) begin
                next_regHit = 1'b1;
                for (int k = 0; k < NUM_BOOST; k++) begin
                    next_regRdata[BOOST_LSB0+2*k +: 2] =
                        read_code(fieldOn[NUM_LED+k]);
                end
            end else if (ledSel) begin
                next_regHit = 1'b1;
                for (int k = 0; k < NUM_LED; k++) begin
                    next_regRdata[LED_LSB0+2*k +: 2] = read_code(fieldOn[k]);
                end
            end
        end
        next_enableState = fieldOn;
        // The global field gates every source; each source its own.
        next_irqOut = fieldOn[GLOBAL_IDX] &&
                      |(faultLatched & fieldOn); // R18 R19
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata    <= '0;
            regHit      <= 1'b0;
            enableState <= '0;
            irqOut      <= 1'b0;
        end else begin
            regRdata    <= next_regRdata;
            regHit      <= next_regHit;
            enableState <= next_enableState;
            irqOut      <= next_irqOut;
        end
    end
endmodule // fault_interrupt_enables

// ==== bench/fault_irq_properties.sv ====
// Purpose: Port checker for the fault interrupt enable registers.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to the top module at the foot.
`timescale 1ns/100ps
module fault_irq_checker #(
    parameter int NUM_SOURCES = 11
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [7:0]             regAddr,
    input wire logic [15:0]            regRdata,
    input wire logic [15:0]            regWdata,
    input wire logic                   regHit,
    input wire logic [NUM_SOURCES-1:0] faultLatched,
    input wire logic [NUM_SOURCES-1:0] enableState,
    input wire logic                   irqOut
);
    wire mapped = regAddr == 8'h0a || regAddr == 8'h0c;
    wire ledWr = regWrite && regAddr == 8'h0c;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_hit_mapped: assert property (regRead && mapped |=> regHit)
        else $error("mapped read gave no hit");
    a_miss_quiet: assert property (regRead && !mapped |=> !regHit && regRdata == 16'h0000)
        else $error("unmapped read was answered");
    a_hit_cause: assert property (regHit |-> $past(regRead) && $past(mapped))
        else $error("hit without a mapped read");
    a_read_codes: assert property (regHit |-> (regRdata & 16'h5555) == 16'h0000)
        else $error("field read code not 0h or 2h");
    a_rsvd_zero: assert property (regHit |->
        ($past(regAddr) != 8'h0a || regRdata[1:0] == 2'h0) &&
        ($past(regAddr) != 8'h0c || regRdata[15:8] == 8'h00))
        else $error("reserved bits read nonzero");
    a_led_on: assert property (ledWr && regWdata[1:0] == 2'h3 ##1 !ledWr |=> enableState[0])
        else $error("enable code did not enable");
    a_led_off: assert property (ledWr && regWdata[1:0] == 2'h1 ##1 !ledWr |=> !enableState[0])
        else $error("disable code did not disable");
    a_irq_cause: assert property (irqOut |-> $past(faultLatched) != '0)
        else $error("interrupt without a fault");
endmodule // fault_irq_checker
bind fault_interrupt_enables fault_irq_checker #(.NUM_SOURCES(NUM_SOURCES)) chk_u (
    .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regRdata(regRdata), .regWdata(regWdata),
    .regHit(regHit), .faultLatched(faultLatched),
    .enableState(enableState), .irqOut(irqOut));

// ==== bench/tb_fault_interrupt_enables.sv ====
// Purpose: Self-checking bench for the fault interrupt enable registers.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Reset values first, then row table, unmapped, interrupt, reset and interrupt cases.
`timescale 1ns/100ps
module tb_fault_interrupt_enables;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic [10:0] faultLatched = 11'h000;
    logic [15:0] regRdata;
    logic        regHit;
    logic [10:0] enableState;
    logic        irqOut;
    int          num_errors = 0;
    int          n_checks = 0;
    logic [7:0]  rowAddr [7] = '{8'h0c, 8'h0c, 8'h0c, 8'h0a, 8'h0a, 8'h0a, 8'h0a};
    logic [15:0] rowData [7] = '{16'h0001, 16'h0054, 16'hffff, 16'h5555,
                                 16'hfffc, 16'h2222, 16'h5040};
    logic [15:0] rowExp [7] = '{16'h00a8, 16'h0000, 16'h00aa, 16'h0000,
                                16'haaa8, 16'haaa8, 16'h0a28};
    fault_interrupt_enables dut_u (
        .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .faultLatched(faultLatched),
        .regRdata(regRdata), .regHit(regHit), .enableState(enableState),
        .irqOut(irqOut));
    initial forever #5 clk = ~clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic h);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        check(regRdata, e);
        check({15'h0000, regHit}, {15'h0000, h});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h0a, 16'ha028, 1'b1);
        rd(8'h0c, 16'h00aa, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wr(rowAddr[i], rowData[i]);
            rd(rowAddr[i], rowExp[i], 1'b1);
        end
        wr(8'h12, 16'hffff);
        rd(8'h12, 16'h0000, 1'b0);
        rd(8'h0c, 16'h00aa, 1'b1);
        faultLatched = 11'h001;
        repeat (3) @(negedge clk);
        check({15'h0000, irqOut}, 16'h0001);
        wr(8'h0c, 16'h0040);
        repeat (3) @(negedge clk);
        check({15'h0000, irqOut}, 16'h0000);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rd(8'h0a, 16'ha028, 1'b1);
        rd(8'h0c, 16'h00aa, 1'b1);
        check({5'h00, enableState}, 16'h063f);
        faultLatched = 11'h010;
        repeat (3) @(negedge clk);
        check({15'h0000, irqOut}, 16'h0001);
        faultLatched = 11'h040;
        repeat (3) @(negedge clk);
        check({15'h0000, irqOut}, 16'h0000);
        faultLatched = 11'h000;
        repeat (3) @(negedge clk);
        check({15'h0000, irqOut}, 16'h0000);
        summarize();
    end
endmodule // tb_fault_interrupt_enables
